// file: lsslc_consts.vh
// Constants for the sixteen-channel sink on/off control block.
// Assumes inclusion by bare name from design files in the same folder.
// Summary of operation
// - Force-off high turns every sink off
// - Force-off low: each sink follows latch bit
// - Undriven force-off defaults high, all off
// - Hold-release high: latch follows shift register
// - Hold-release low: latch keeps its contents
// - Shift clock edge moves bits toward MSB
// - Serial input loads into LSB each edge
// - Serial output shows MSB, updates on edges
// - Latch bit n drives sink channel n
// - Force-off pulse on-time error within 45 ns
// - Nine groups: 0, pairs k/16-k, 8
`ifndef LSSLC_CONSTS_VH
`define LSSLC_CONSTS_VH
`define LSSLC_CHANNELS      16
`define LSSLC_GROUPS        9
`define LSSLC_CLK_PERIOD_PS 4000
`define LSSLC_GROUP_STEP_PS 2000
`define LSSLC_ON_ERR_PS     45000
`define LSSLC_STEP_CYCLES   ((`LSSLC_GROUP_STEP_PS < `LSSLC_CLK_PERIOD_PS) ? 1 : (`LSSLC_GROUP_STEP_PS / `LSSLC_CLK_PERIOD_PS))
`define LSSLC_FIFO_WIDTH    16
`define LSSLC_FIFO_DEPTH    4
`endif

// file: lsslc_ctrl.v
// Top of the sink on/off control: shift register, hold latch, staggered
// outputs. Pins arrive asynchronous to i_ref_clk and are synchronised;
// the shift clock is sampled and its rising edge detected in-domain.
`timescale 1ns/1ps
`include "lsslc_consts.vh"
module lsslc_ctrl #(
  parameter CH   = `LSSLC_CHANNELS,
  parameter STEP = `LSSLC_STEP_CYCLES
) (
  input  wire          i_ref_clk,
  input  wire          i_rstn,
  input  wire          i_shift_clock,
  input  wire          i_serial_in,
  input  wire          i_hold_release,
  input  wire          i_force_off,
  input  wire          i_force_off_driven,
  output reg           o_serial_out,
  output reg  [CH-1:0] o_sink_channel,
  output reg           o_snap_dropped
);
  localparam ST_IDLE = 1'b0;
  localparam ST_STEP = 1'b1;

  reg  [2:0]    sclk_sync;
  reg  [1:0]    sin_sync;
  reg  [1:0]    hold_sync;
  reg  [1:0]    force_sync;
  reg  [1:0]    drv_sync;
  reg  [CH-1:0] shift_reg;
  reg  [CH-1:0] hold_latch;
  reg  [CH-1:0] target;
  reg  [CH-1:0] next_target;
  reg  [CH-1:0] applied;
  reg  [CH-1:0] next_applied;
  reg  [CH-1:0] last_sent;
  reg           state;
  reg  [3:0]    group_idx;
  reg  [7:0]    step_cnt;
  wire [CH-1:0] group_mask [0:`LSSLC_GROUPS-1];
  wire [CH-1:0] cur_mask;
  wire          sclk_rise;
  wire          force_eff;
  wire [CH-1:0] latch_next;
  wire [CH-1:0] gated;
  wire [CH-1:0] fifo_data;
  wire          fifo_valid;
  wire          fifo_ready;
  wire          snap_push;
  reg           fifo_take;
  genvar        gi;

  // First-stage flops read only by the next flop
  assign sclk_rise = sclk_sync[2] == 1'b0 && sclk_sync[1] == 1'b1 ? 1'b1
                                                                 : 1'b0;
  // Undriven pin reads high, as with the pull-up
  assign force_eff = force_sync[1] | ~drv_sync[1];
  // Transparent while high, hold while low
  assign latch_next = hold_sync[1] ? shift_reg : hold_latch;
  // Force-off blanks everything
  assign gated = force_eff ? {CH{1'b0}} : hold_latch;
  assign snap_push = (gated != last_sent);

  // Group table: 0 alone, pairs k and CH-k, then CH/2 alone
  // Wires, so the table holds from time zero without any trigger
  generate
    for (gi = 0; gi < `LSSLC_GROUPS; gi = gi + 1) begin : g_mask
      if (gi == 0) begin : g_first
        assign group_mask[gi] = {{(CH-1){1'b0}}, 1'b1};
      end else if (gi == `LSSLC_GROUPS - 1) begin : g_last
        assign group_mask[gi] = {{(CH-1){1'b0}}, 1'b1} << (CH/2);
      end else begin : g_pair
        assign group_mask[gi] = ({{(CH-1){1'b0}}, 1'b1} << gi) |
                                ({{(CH-1){1'b0}}, 1'b1} << (CH - gi));
      end
    end
  endgenerate

  assign cur_mask = group_mask[group_idx];

  always @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      sclk_sync  <= 3'h0;
      sin_sync   <= 2'h0;
      hold_sync  <= 2'h0;
      force_sync <= 2'h3;
      drv_sync   <= 2'h0;
    end else begin
      sclk_sync  <= {sclk_sync[1:0], i_shift_clock};
      sin_sync   <= {sin_sync[0], i_serial_in};
      hold_sync  <= {hold_sync[0], i_hold_release};
      force_sync <= {force_sync[0], i_force_off};
      drv_sync   <= {drv_sync[0], i_force_off_driven};
    end
  end

  // Data path has no reset: contents start undefined
  always @(posedge i_ref_clk) begin
    if (sclk_rise) begin
      // Shift toward MSB, serial in to LSB
      shift_reg <= {shift_reg[CH-2:0], sin_sync[1]};
    end
    hold_latch <= latch_next;
  end

  // Serial out only moves with a shift edge
  always @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_serial_out <= 1'b0;
    end else if (sclk_rise) begin
      o_serial_out <= shift_reg[CH-2];
    end
  end

  // Snapshots queue so a burst of up to 4 changes is not lost mid-stagger
  lsslc_fifo #(
    .WIDTH (CH),
    .DEPTH (`LSSLC_FIFO_DEPTH),
    .AW    (2)
  ) u_fifo (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .i_data    (gated),
    .i_valid   (snap_push),
    .o_ready   (fifo_ready),
    .o_data    (fifo_data),
    .o_valid   (fifo_valid),
    .i_ready   (fifo_take)
  );

  always @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      last_sent      <= {CH{1'b0}};
      o_snap_dropped <= 1'b0;
    end else begin
      if (snap_push & fifo_ready) begin
        last_sent <= gated;
      end
      // Full queue stalls the push; flagged for observation only
      o_snap_dropped <= snap_push & ~fifo_ready;
    end
  end

  always @* begin
    fifo_take    = 1'b0;
    next_target  = target;
    next_applied = applied;
    case (state)
      ST_IDLE: begin
        fifo_take = fifo_valid;
        if (fifo_valid) begin
          next_target = fifo_data;
        end
      end
      ST_STEP: begin
        if (step_cnt == 8'h00) begin
          // One group per step, channel n from bit n
          next_applied = (applied & ~cur_mask) |
                         (target & cur_mask);
        end
      end
      default: begin
        fifo_take = 1'b0;
      end
    endcase
  end

  // Whole stagger spans 8 x STEP + 1 cycles, under the error bound
  always @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      state          <= ST_IDLE;
      target         <= {CH{1'b0}};
      applied        <= {CH{1'b0}};
      group_idx      <= 4'h0;
      step_cnt       <= 8'h00;
      o_sink_channel <= {CH{1'b0}};
    end else begin
      target         <= next_target;
      applied        <= next_applied;
      o_sink_channel <= next_applied;
      case (state)
        ST_IDLE: begin
          if (fifo_valid) begin
            state     <= ST_STEP;
            group_idx <= 4'h0;
            step_cnt  <= 8'h00;
          end
        end
        ST_STEP: begin
          if (step_cnt != 8'h00) begin
            step_cnt <= step_cnt - 8'h01;
          end else if (group_idx == `LSSLC_GROUPS - 1) begin
            state <= ST_IDLE;
          end else begin
            group_idx <= group_idx + 4'h1;
            step_cnt  <= STEP[7:0] - 8'h01;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// file: lsslc_ctrl_assertions.sv
// Checker for the sink control pins, bound into lsslc_ctrl.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/1ps
module lsslc_chk #(
  parameter CH   = 16,
  parameter STEP = 1
) (
  input logic          i_ref_clk,
  input logic          i_rstn,
  input logic          i_shift_clock,
  input logic          i_hold_release,
  input logic          i_force_off,
  input logic          i_force_off_driven,
  input logic          o_serial_out,
  input logic [CH-1:0] o_sink_channel
);
  logic [6:0] blank_cnt;
  logic [6:0] quiet_cnt;
  wire        blank = i_force_off | ~i_force_off_driven;
  // Saturating, so a long quiet spell keeps the check armed
  always @(posedge i_ref_clk) begin
    if (!i_rstn || !blank) blank_cnt <= 7'h00;
    else if (!(&blank_cnt)) blank_cnt <= blank_cnt + 7'h01;
    if (!i_rstn || blank || i_hold_release) quiet_cnt <= 7'h00;
    else if (!(&quiet_cnt)) quiet_cnt <= quiet_cnt + 7'h01;
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  sequence s_edge_seen;
    $past(i_shift_clock, 3) || $past(i_shift_clock, 4);
  endsequence
  sequence s_clk_idle;
    !i_shift_clock [*6];
  endsequence
  // Margin covers a full snapshot queue draining ahead of the blank
  a_blank_off: assert property (
    blank_cnt >= 7'h50 |-> o_sink_channel == '0) else $error("blank");
  a_hold_keeps: assert property (
    quiet_cnt >= 7'h64 |-> $stable(o_sink_channel)) else $error("hold");
  a_serial_out_edge: assert property (
    $changed(o_serial_out) |-> s_edge_seen) else $error("serial_out edge");
  a_serial_out_idle: assert property (
    s_clk_idle |-> $stable(o_serial_out)) else $error("serial_out idle");
  a_group_first: assert property (
    $changed(o_sink_channel[0]) |-> $stable(o_sink_channel[CH-1:1]))
    else $error("group0");
  a_pair_one: assert property (
    $changed(o_sink_channel[1]) |-> $stable(o_sink_channel[14:2]))
    else $error("group1");
  a_group_last: assert property (
    $changed(o_sink_channel[8]) |-> $stable(o_sink_channel[7:1])
    && $stable(o_sink_channel[15:9])) else $error("group8");
  a_reset_off: assert property (
    @(posedge i_ref_clk) disable iff (1'b0)
    !i_rstn |=> o_sink_channel == '0 && !o_serial_out) else $error("reset");
endmodule
bind lsslc_ctrl lsslc_chk #(.CH(CH), .STEP(STEP)) u_chk (
  .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_shift_clock(i_shift_clock),
  .i_hold_release(i_hold_release), .i_force_off(i_force_off),
  .i_force_off_driven(i_force_off_driven), .o_serial_out(o_serial_out),
  .o_sink_channel(o_sink_channel));

// file: lsslc_fifo.v
// Small synchronous FIFO carrying latch snapshots to the output stagger.
// Assumes a single clock and a synchronous active-low reset.
`timescale 1ns/1ps
module lsslc_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             i_ref_clk,
  input  wire             i_rstn,
  input  wire [WIDTH-1:0] i_data,
  input  wire             i_valid,
  output wire             o_ready,
  output wire [WIDTH-1:0] o_data,
  output wire             o_valid,
  input  wire             i_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            do_wr;
  wire            do_rd;
  integer         k;

  assign o_ready = (count != DEPTH[AW:0]);
  assign o_valid = (count != {(AW+1){1'b0}});
  assign o_data  = mem[rd_ptr];
  assign do_wr   = i_valid & o_ready;
  assign do_rd   = o_valid & i_ready;

  always @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
      for (k = 0; k < DEPTH; k = k + 1) begin
        mem[k] <= {WIDTH{1'b0}};
      end
    end else begin
      if (do_wr) begin
        mem[wr_ptr] <= i_data;
        wr_ptr      <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                       : wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                  : rd_ptr + 1'b1;
      end
      if (do_wr & ~do_rd) begin
        count <= count + 1'b1;
      end else if (do_rd & ~do_wr) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// file: lsslc_host.sv
// Host model driving the shift, hold and blanking pins.
// Assumes the bench calls its tasks; pins move 1 ns after an edge.
`timescale 1ns/1ps
module lsslc_host (
  input  logic i_ref_clk,
  output logic o_shift_clock,
  output logic o_serial_in,
  output logic o_hold_release,
  output logic o_force_off,
  output logic o_force_driven
);
  // Blanked from time zero: latch contents unknown until loaded
  // Data and hold pins stay unset until a task first drives them
  initial begin
    o_shift_clock  = 1'b0;
    o_force_off    = 1'b1;
    o_force_driven = 1'b1;
  end
  task automatic step(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic shift_bit(input logic b);
    step(1);
    o_serial_in = b;
    step(1);
    o_shift_clock = 1'b1;
    step(4);
    o_shift_clock = 1'b0;
    o_serial_in = ~b; // Hold over: no stale level left
    step(3);
  endtask
  task automatic shift_word(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) shift_bit(w[i]);
  endtask
  task automatic set_pins(input logic h, input logic f, input logic d);
    step(1);
    {o_hold_release, o_force_off, o_force_driven} = {h, f, d};
  endtask
endmodule

// file: testbench.sv
// Bench for lsslc_ctrl, with the host model on its pins.
// Assumes the design settles sinks well within 150 clocks.
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
  $display("Error %0t: got %h want %h", $time, a, b); end end
module testbench;
  logic        i_ref_clk = 1'b0;
  logic        i_rstn    = 1'b0;
  wire         sc, si, hr, fo, fd, so, drop;
  wire  [15:0] sink;
  int          fail_count = 0;
  int          comparisons = 0;
  int          drops = 0;
  always #2 i_ref_clk = ~i_ref_clk;
  always @(negedge i_ref_clk) if (drop === 1'b1) drops++;
  lsslc_host u_host (.i_ref_clk(i_ref_clk), .o_shift_clock(sc),
    .o_serial_in(si), .o_hold_release(hr), .o_force_off(fo),
    .o_force_driven(fd));
  lsslc_ctrl u_dut (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
    .i_shift_clock(sc), .i_serial_in(si), .i_hold_release(hr),
    .i_force_off(fo), .i_force_off_driven(fd), .o_serial_out(so),
    .o_sink_channel(sink), .o_snap_dropped(drop));
  task automatic close_out;
    $display("Comparisons %0d, errors %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wait_sink(input logic [15:0] e);
    for (int n = 0; n < 150 && sink !== e; n++) u_host.step(1);
    `CHK(sink, e)
    if (sink !== e) close_out();
  endtask
  task automatic t_blank;
    u_host.shift_word(16'h5a3c);
    u_host.set_pins(1'b1, 1'b1, 1'b1);
    u_host.step(2);
    u_host.set_pins(1'b0, 1'b1, 1'b1);
    u_host.step(40);
    `CHK(sink, 16'h0000)
    u_host.set_pins(1'b0, 1'b0, 1'b1);
    wait_sink(16'h5a3c);
  endtask
  task automatic t_hold;
    u_host.shift_word(16'h9c35);
    u_host.step(40);
    `CHK(sink, 16'h5a3c)
    `CHK(so, 1'b1)
    u_host.set_pins(1'b1, 1'b0, 1'b1);
    wait_sink(16'h9c35);
    u_host.shift_bit(1'b0);
    wait_sink(16'h386a);
    `CHK(so, 1'b0)
    u_host.set_pins(1'b0, 1'b0, 1'b1);
  endtask
  task automatic t_stagger;
    u_host.set_pins(1'b0, 1'b0, 1'b0);
    wait_sink(16'h0000);
    u_host.set_pins(1'b0, 1'b0, 1'b1);
    for (int n = 0; n < 150 && sink[1] !== 1'b1; n++) u_host.step(1);
    `CHK(sink, 16'h0002)
    wait_sink(16'h386a);
  endtask
  task automatic t_fill;
    drops = 0;
    for (int k = 0; k < 20; k++) u_host.set_pins(1'b0, ~k[0], 1'b1);
    `CHK(drops != 0, 1'b1)
    wait_sink(16'h386a);
    u_host.step(60);
    `CHK(sink, 16'h386a)
  endtask
  initial begin
    repeat (12) @(posedge i_ref_clk);
    #1 i_rstn = 1'b1;
    t_blank();
    t_hold();
    t_stagger();
    t_fill();
    close_out();
  end
endmodule
